// ==== pot_cfg.svh ====
// Constants for the dual potentiometer serial command block
`ifndef POT_CFG_SVH
`define POT_CFG_SVH

// Clock and operation times
`define CLK_PERIOD_NS 4
`define CMD8_TIME_US 20
`define READ_TIME_US 7
`define STORE_TIME_MS 15
`define PRESET_TIME_US 30

// Command word layout
`define FRAME_BITS 24
`define FRAME_MSB 23
`define INSTR_MSB 23
`define INSTR_LSB 20
`define ADDR_MSB 19
`define ADDR_LSB 16
`define DATA_MSB 9
`define DATA_LSB 0
`define WIPER_W 10
`define NV_RESET 10'h200

// Instruction codes
`define INSTR_NOP 4'h0
`define INSTR_RESTORE 4'h1
`define INSTR_STORE_WIPER 4'h2
`define INSTR_STORE_DATA 4'h3
`define INSTR_RESTORE_ALL 4'h8
`define INSTR_READ_NV 4'h9
`define INSTR_READ_WIPER 4'hA
`define INSTR_WRITE_WIPER 4'hB

// Wiper addresses
`define ADDR_WIPER_A 4'h0
`define ADDR_WIPER_B 4'h1

// Synchroniser bit positions
`define SYN_SCLK 0
`define SYN_SIN 1
`define SYN_CS 2
`define SYN_WP 3
`define SYN_PR 4
`define SYNC_IDLE 5'h1C

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_WIPER_A 8'h08
`define REG_WIPER_B 8'h0C
`define REG_NV_A 8'h10
`define REG_NV_B 8'h14
`define CTRL_RESET 1'b1

// Bus encodings
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'b0
`define BUSY_CNT_W 22

`endif

// ==== pot_pkg.sv ====
// Types shared by the dual potentiometer serial command block
package pot_pkg;
  typedef logic [9:0] wiper_t;
  typedef enum logic {st_idle, st_busy} busy_state_t;
endpackage

// ==== dual_pot_serial_interface.sv ====
// Serial command decoder, wiper and stored value logic, bus registers
// Function
// - Sample one input bit per rising clock
// - Data shifted in most significant bit first
// - Readback commands 9, 10 drive data out
// - Other commands shift previous pattern out
// - Execute command only when select rises
// - Write protect low blocks changes except preset
// - Instructions 1 and 8 restore wiper
// - Preset rising edge reloads wipers from store
// - Store holds midscale 512 until written
// - Ready low for 2,3,8,9,10 and preset
// - Ready low durations per operation type
// - Address 0 is wiper A, 1 wiper B
// - Clock idle high: extra bit is previous LSB
// - Clock idle low: extra bit is received MSB
`include "pot_cfg.svh"

module dual_pot_serial_interface #(
  parameter int CMD8_CYCLES = (`CMD8_TIME_US * 1000) / `CLK_PERIOD_NS,
  parameter int STORE_CYCLES = (`STORE_TIME_MS * 1000000) / `CLK_PERIOD_NS,
  parameter int PRESET_CYCLES = (`PRESET_TIME_US * 1000) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial pins
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic cs_n,
  output logic serial_out,
  output logic serial_out_oe_n,
  // Control pins
  input wire logic wp_n,
  input wire logic preset_reload_n,
  output logic ready_out,
  output logic ready_oe_n,
  // Wiper positions
  output pot_pkg::wiper_t wiper_a,
  output pot_pkg::wiper_t wiper_b
);
  import pot_pkg::*;

  localparam int READ_CYCLES = (`READ_TIME_US * 1000) / `CLK_PERIOD_NS;

  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] sync_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic pr_rise;
  logic cs_low;
  logic wp_low;
  logic [`FRAME_MSB:0] shift_reg;
  logic [3:0] instr;
  logic [3:0] addr;
  logic addr_ok;
  logic idx;
  wiper_t data;
  wiper_t wiper [2];
  wiper_t nv_store [2];
  busy_state_t state;
  logic [`BUSY_CNT_W-1:0] busy_cnt;
  logic start_busy;
  logic [`BUSY_CNT_W-1:0] next_busy_cnt;
  logic exec;
  logic ctrl_enable;
  logic [3:0] last_instr;
  logic bus_write;
  logic [7:0] bus_addr;
  logic [31:0] next_rdata;

  // Two-stage synchronisers for all pin inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= `SYNC_IDLE;
      sync_b <= `SYNC_IDLE;
      sync_prev <= `SYNC_IDLE;
    end else begin
      sync_a <= {preset_reload_n, wp_n, cs_n, serial_in, sclk};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  assign sclk_rise = sync_b[`SYN_SCLK] & ~sync_prev[`SYN_SCLK];
  assign sclk_fall = ~sync_b[`SYN_SCLK] & sync_prev[`SYN_SCLK];
  assign cs_rise = sync_b[`SYN_CS] & ~sync_prev[`SYN_CS];
  assign pr_rise = sync_b[`SYN_PR] & ~sync_prev[`SYN_PR];
  assign cs_low = ~sync_b[`SYN_CS];
  assign wp_low = ~sync_b[`SYN_WP];

  // Command fields
  assign instr = shift_reg[`INSTR_MSB:`INSTR_LSB];
  assign addr = shift_reg[`ADDR_MSB:`ADDR_LSB];
  assign data = shift_reg[`DATA_MSB:`DATA_LSB];
  assign addr_ok = (addr == `ADDR_WIPER_A) || (addr == `ADDR_WIPER_B);
  assign idx = addr[0];
  assign exec = cs_rise && ctrl_enable && (state == st_idle);

  // Serial input register and readback load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg <= '0;
    end else if (cs_low && sclk_rise) begin
      shift_reg <= {shift_reg[`FRAME_MSB-1:0], sync_b[`SYN_SIN]};
    end else if (exec && addr_ok && instr == `INSTR_READ_NV) begin
      shift_reg <= {{(`FRAME_BITS-`WIPER_W){1'b0}}, nv_store[idx]};
    end else if (exec && addr_ok && instr == `INSTR_READ_WIPER) begin
      shift_reg <= {{(`FRAME_BITS-`WIPER_W){1'b0}}, wiper[idx]};
    end
  end

  // Serial output follows the register head on falling clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out <= 1'b1;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_oe_n <= ~cs_low;
      if (cs_low && sclk_fall) begin
        serial_out <= shift_reg[`FRAME_MSB];
      end
    end
  end

  // Wiper and stored value updates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wiper[0] <= `NV_RESET;
      wiper[1] <= `NV_RESET;
      nv_store[0] <= `NV_RESET;
      nv_store[1] <= `NV_RESET;
    end else if (pr_rise) begin
      wiper[0] <= nv_store[0];
      wiper[1] <= nv_store[1];
    end else if (exec && !wp_low) begin
      unique case (instr)
        `INSTR_RESTORE: begin
          if (addr_ok) begin
            wiper[idx] <= nv_store[idx];
          end
        end
        `INSTR_RESTORE_ALL: begin
          wiper[0] <= nv_store[0];
          wiper[1] <= nv_store[1];
        end
        `INSTR_STORE_WIPER: begin
          if (addr_ok) begin
            nv_store[idx] <= wiper[idx];
          end
        end
        `INSTR_STORE_DATA: begin
          if (addr_ok) begin
            nv_store[idx] <= data;
          end
        end
        `INSTR_WRITE_WIPER: begin
          if (addr_ok) begin
            wiper[idx] <= data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Wiper outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wiper_a <= `NV_RESET;
      wiper_b <= `NV_RESET;
    end else begin
      wiper_a <= wiper[0];
      wiper_b <= wiper[1];
    end
  end

  // Busy duration selection
  always_comb begin
    start_busy = 1'b1;
    next_busy_cnt = '0;
    if (pr_rise) begin
      next_busy_cnt = `BUSY_CNT_W'(PRESET_CYCLES - 1);
    end else if (exec) begin
      unique case (instr)
        `INSTR_STORE_WIPER, `INSTR_STORE_DATA: begin
          next_busy_cnt = `BUSY_CNT_W'(STORE_CYCLES - 1);
        end
        `INSTR_RESTORE_ALL: begin
          next_busy_cnt = `BUSY_CNT_W'(CMD8_CYCLES - 1);
        end
        `INSTR_READ_NV, `INSTR_READ_WIPER: begin
          next_busy_cnt = `BUSY_CNT_W'(READ_CYCLES - 1);
        end
        default: begin
          start_busy = 1'b0;
        end
      endcase
    end else begin
      start_busy = 1'b0;
    end
  end

  // Ready timer; the open-drain pin is pulled low while busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= st_idle;
      busy_cnt <= '0;
      ready_oe_n <= 1'b1;
      ready_out <= 1'b0;
    end else if (start_busy) begin
      state <= st_busy;
      busy_cnt <= next_busy_cnt;
      ready_oe_n <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          ready_oe_n <= 1'b1;
        end
        st_busy: begin
          if (busy_cnt == '0) begin
            state <= st_idle;
            ready_oe_n <= 1'b1;
          end else begin
            busy_cnt <= busy_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // Last executed instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_instr <= `INSTR_NOP;
    end else if (exec) begin
      last_instr <= instr;
    end
  end

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_write <= 1'b0;
      bus_addr <= '0;
    end else if (hready) begin
      bus_write <= hsel && htrans == `HTRANS_NONSEQ && hwrite;
      bus_addr <= haddr[7:0];
    end
  end

  // Control register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_enable <= `CTRL_RESET;
    end else if (bus_write && bus_addr == `REG_CTRL) begin
      ctrl_enable <= hwdata[0];
    end
  end

  // Read data selection
  always_comb begin
    next_rdata = '0;
    unique case (haddr[7:0])
      `REG_CTRL: next_rdata = {31'h0, ctrl_enable};
      `REG_STATUS: next_rdata = {24'h0, last_instr, 1'b0, wp_low, 1'b0, state == st_busy};
      `REG_WIPER_A: next_rdata = {22'h0, wiper[0]};
      `REG_WIPER_B: next_rdata = {22'h0, wiper[1]};
      `REG_NV_A: next_rdata = {22'h0, nv_store[0]};
      `REG_NV_B: next_rdata = {22'h0, nv_store[1]};
      default: next_rdata = '0;
    endcase
  end

  // Read data register and zero-wait OKAY response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
      if (hready && hsel && htrans == `HTRANS_NONSEQ && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

endmodule

// ==== dual_pot_serial_interface_sva.sv ====
// Port checker for the dual potentiometer serial block
module dual_pot_sva (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Serial and control pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic wp_n,
  input wire logic preset_reload_n,
  input wire logic ready_out,
  input wire logic ready_oe_n,
  // Wipers
  input wire pot_pkg::wiper_t wiper_a,
  input wire pot_pkg::wiper_t wiper_b
);
  import pot_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Longest busy span with default timings, with margin for a preset restart
  localparam int LOW_LIMIT = 3760000;
  logic [21:0] low_cnt;
  // Cycles that ready has been held low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= '0;
    end else if (ready_oe_n) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 22'h1;
    end
  end
  bus_okay_a: assert property (hresp == 1'b0 && hreadyout)
    else $error("bus answer not okay");
  out_drive_a: assert property (!cs_n [*4] |-> !serial_out_oe_n)
    else $error("serial out not driven");
  out_release_a: assert property (cs_n [*4] |-> serial_out_oe_n)
    else $error("serial out not released");
  out_on_fall_a: assert property ($changed(serial_out) && !serial_out_oe_n |-> !$past(sclk, 2))
    else $error("serial out moved off a falling clock");
  wp_hold_a: assert property ((!wp_n && preset_reload_n && ready_oe_n) [*8]
    |-> $stable({wiper_a, wiper_b}))
    else $error("wiper changed under write protect");
  busy_min_a: assert property ($fell(ready_oe_n) |-> !ready_oe_n [*8])
    else $error("ready came back too soon");
  busy_end_a: assert property (low_cnt <= LOW_LIMIT)
    else $error("ready never came back");
  preset_busy_a: assert property ($rose(preset_reload_n) |-> ##[2:8] !ready_oe_n)
    else $error("preset did not mark busy");
  ready_level_a: assert property (ready_out == 1'b0)
    else $error("ready pin driven high");
  exec_on_cs_a: assert property ($fell(ready_oe_n) && preset_reload_n |-> $past(cs_n, 2))
    else $error("command ran while selected");
  cover property ($fell(ready_oe_n));
  cover property ($rose(preset_reload_n));
  cover property ($rose(cs_n));
endmodule

bind dual_pot_serial_interface dual_pot_sva dual_pot_sva_inst (.*);

// ==== pot_host_model.sv ====
// Serial host model that sends command frames
module pot_host_model (
  // Serial pins
  output logic sclk,
  output logic serial_in,
  output logic cs_n,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic ready_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up on the released output line
  wire so = serial_out_oe_n | serial_out;
  initial begin
    sclk = 1'b0;
    serial_in = 1'b0;
    cs_n = 1'b1;
  end
  task automatic frame(input logic [23:0] w, output logic [23:0] rx);
    wait (ready_oe_n === 1'b1);
    #3 cs_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      serial_in = w[23 - i];
      #16 sclk = 1'b1;
      #14 rx = {rx[22:0], so};
      #2 sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule

// ==== dual_pot_serial_interface_tb.sv ====
// Self-checking bench for the dual potentiometer serial block
`include "pot_cfg.svh"
module dual_pot_serial_interface_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pot_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic wp_n = 1'b1, preset_reload_n = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, serial_out, serial_out_oe_n, ready_out, ready_oe_n;
  logic sclk, serial_in, cs_n;
  wiper_t wiper_a, wiper_b;
  logic [23:0] exp_rx = 24'h0, mask = 24'h0, rx;
  int seed = 1, mismatches = 0, n_compared = 0;
  dual_pot_serial_interface #(.CMD8_CYCLES(10), .STORE_CYCLES(20), .PRESET_CYCLES(12))
    dual_pot_serial_interface_inst (.*, .hsize(3'h2), .hready(hreadyout));
  pot_host_model pot_host_model_inst (.sclk, .serial_in, .cs_n, .serial_out,
    .serial_out_oe_n, .ready_oe_n);
  initial forever #2 hclk = ~hclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [31:0] want);
    bus(a, 1'b0, 32'h0);
    check(rd, want);
  endtask
  task automatic settle();
    repeat (8) @(posedge hclk);
    wait (ready_oe_n === 1'b1);
    @(posedge hclk);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] ad, input logic [9:0] d);
    pot_host_model_inst.frame({op, ad, 6'h0, d}, rx);
    check({8'h0, rx & mask}, {8'h0, exp_rx & mask});
    exp_rx = {op, ad, 6'h0, d};
    mask = 24'hFFFFFF;
    settle();
  endtask
  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  initial begin
    logic [9:0] a;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reg_is(`REG_WIPER_A, 32'h200);
    reg_is(`REG_NV_B, 32'h200);
    reg_is(8'h40, 32'h0);
    for (int i = 0; i < 3; i++) begin
      a = 10'($random(seed));
      cmd(`INSTR_WRITE_WIPER, `ADDR_WIPER_B, ~a);
      cmd(`INSTR_WRITE_WIPER, `ADDR_WIPER_A, a);
      reg_is(`REG_WIPER_A, {22'h0, a});
      reg_is(`REG_WIPER_B, {22'h0, ~a});
      check({22'h0, wiper_a}, {22'h0, a});
      check({22'h0, wiper_b}, {22'h0, ~a});
    end
    cmd(`INSTR_STORE_WIPER, `ADDR_WIPER_A, 10'h0);
    reg_is(`REG_NV_A, {22'h0, a});
    cmd(`INSTR_STORE_DATA, `ADDR_WIPER_B, 10'h3FF);
    reg_is(`REG_NV_B, 32'h3FF);
    cmd(`INSTR_READ_NV, `ADDR_WIPER_B, 10'h0);
    exp_rx = 24'h3FF;
    mask = 24'h3FF;
    cmd(`INSTR_READ_WIPER, `ADDR_WIPER_A, 10'h0);
    exp_rx = {14'h0, a};
    mask = 24'h3FF;
    cmd(`INSTR_WRITE_WIPER, `ADDR_WIPER_A, 10'h001);
    cmd(`INSTR_RESTORE, `ADDR_WIPER_A, 10'h0);
    cmd(`INSTR_NOP, 4'h0, 10'h0);
    reg_is(`REG_WIPER_A, {22'h0, a});
    cmd(`INSTR_WRITE_WIPER, `ADDR_WIPER_B, 10'h00F);
    cmd(`INSTR_RESTORE_ALL, 4'h0, 10'h0);
    reg_is(`REG_WIPER_B, 32'h3FF);
    cmd(`INSTR_WRITE_WIPER, `ADDR_WIPER_B, 10'h0F0);
    wp_n <= 1'b0;
    cmd(`INSTR_WRITE_WIPER, `ADDR_WIPER_A, 10'h055);
    cmd(`INSTR_STORE_DATA, `ADDR_WIPER_A, 10'h055);
    cmd(`INSTR_NOP, 4'h0, 10'h0);
    reg_is(`REG_WIPER_A, {22'h0, a});
    reg_is(`REG_NV_A, {22'h0, a});
    reg_is(`REG_STATUS, 32'h4);
    preset_reload_n <= 1'b0;
    repeat (20) @(posedge hclk);
    preset_reload_n <= 1'b1;
    settle();
    reg_is(`REG_WIPER_B, 32'h3FF);
    wp_n <= 1'b1;
    bus(`REG_CTRL, 1'b1, 32'h0);
    cmd(`INSTR_WRITE_WIPER, `ADDR_WIPER_A, 10'h2AA);
    reg_is(`REG_WIPER_A, {22'h0, a});
    bus(`REG_CTRL, 1'b1, 32'h1);
    cmd(`INSTR_NOP, 4'h0, 10'h0);
    finish_test();
  end
endmodule
